/* File: alc_regs.vh */
// register map, field positions, reset values and level constants for the level control block
`ifndef ALC_REGS_VH
`define ALC_REGS_VH

// register byte offsets
`define ALC_OFS_CTRL 8'h00
`define ALC_OFS_CFG 8'h04
`define ALC_OFS_CEIL 8'h08
`define ALC_OFS_LGAIN 8'h0C
`define ALC_OFS_RGAIN 8'h10
`define ALC_OFS_STAT 8'h14

// control register bits
`define ALC_CTRL_EN 0
`define ALC_CTRL_ZCD 1
`define ALC_CTRL_ADCL 2
`define ALC_CTRL_ADCR 3
`define ALC_CTRL_DAC 4

// configuration register fields
`define ALC_CFG_THR 1:0
`define ALC_CFG_ATT 3:2
`define ALC_CFG_ZTM 5:4
`define ALC_CFG_WTM 8:6
`define ALC_CFG_RGN 10:9
`define ALC_CFG_FST 12:11

// status register fields
`define ALC_ST_GL 7:0
`define ALC_ST_GR 15:8
`define ALC_ST_ACT 16
`define ALC_ST_REC 17
`define ALC_ST_LIM 18
`define ALC_ST_IMP 19

// reset values
`define ALC_RST_CTRL 5'h00
`define ALC_RST_CFG 13'h0000
`define ALC_RST_GAIN 8'hE1

// gain code limits: 00 is mute, F1 is +36 dB
`define ALC_GAIN_MIN 8'h00
`define ALC_GAIN_MAX 8'hF1

// timing bases, counted in sample periods
`define ALC_ZTM_BASE 11'h080
`define ALC_WTM_BASE 15'h0080

// sample magnitudes on a 16-bit full scale
`define ALC_LVL_2P5 17'h05FFD
`define ALC_LVL_4P1 17'h04FD5
`define ALC_LVL_6P0 17'h04027
`define ALC_LVL_8P5 17'h0301A
`define ALC_LVL_12P0 17'h02027

// fast recovery divider shifts
`define ALC_FST_X4 4'h2
`define ALC_FST_X8 4'h3
`define ALC_FST_X16 4'h4
`define ALC_FST_NONE 4'h0

`endif

/* File: alc_level_control.v */
// automatic level control of the shared input volume gain, with apb register access
//
// Overview of operation
// - level control runs only while enable set
// - dac only: playback path; adc powered: recording
// - either channel over limit: attenuate, gains equal
// - zero cross on: apply at own crossing/timeout
// - zero cross off: change each sample, one step
// - attenuate until level falls; repeat when exceeded
// - threshold field picks detect and reset levels
// - attenuation field picks 1, 2, 4, 8 steps
// - timeout field picks 128 to 1024 samples
// - recover only after quiet full waiting period
// - wait field picks 128 to 16384 samples
// - recovery raises both gains, zero cross timed
// - recovery field picks 1 to 4 steps
// - step per wait, or per timeout if longer
// - early crossings still wait whole period
// - recovery never exceeds the ceiling code
// - reset wait timer inside reset band
// - impulse noise recovers 4, 8, 16 times faster
// - gain codes in 0.375 dB, F1 max, 00 mute
// - manual gain writes ignored while active
// - start from left gain within bounded time
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "alc_regs.vh"

module alc_level_control (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire sample_valid,
   input wire [15:0] sample_left,
   input wire [15:0] sample_right,
   output reg [7:0] left_input_gain_code,
   output reg [7:0] right_input_gain_code,
   output reg path_recording,
   output reg level_control_active
);

   // software registers
   reg [4:0] ctrl_ff;
   reg [12:0] cfg_ff;
   reg [7:0] recovery_ceiling_code_ff;
   reg [7:0] man_left_ff;
   reg [7:0] man_right_ff;

   // level control state
   reg [7:0] tgt_left_ff;
   reg [7:0] tgt_right_ff;
   reg pend_left_ff;
   reg pend_right_ff;
   reg [10:0] tmo_cnt_ff;
   reg [14:0] wait_cnt_ff;
   reg sign_left_ff;
   reg sign_right_ff;
   reg en_prev_ff;
   reg limiting_ff;
   reg over_prev_ff;
   reg over_run_ff;
   reg impulse_ff;

   // control fields
   wire level_control_enable = ctrl_ff[`ALC_CTRL_EN];
   wire zero_cross_disable = ctrl_ff[`ALC_CTRL_ZCD];
   wire adc_left_power = ctrl_ff[`ALC_CTRL_ADCL];
   wire adc_right_power = ctrl_ff[`ALC_CTRL_ADCR];
   wire dac_power = ctrl_ff[`ALC_CTRL_DAC];
   wire [1:0] limit_threshold_select = cfg_ff[`ALC_CFG_THR];
   wire [1:0] attenuation_step_select = cfg_ff[`ALC_CFG_ATT];
   wire [1:0] zero_cross_timeout_select = cfg_ff[`ALC_CFG_ZTM];
   wire [2:0] recovery_wait_select = cfg_ff[`ALC_CFG_WTM];
   wire [1:0] recovery_step_select = cfg_ff[`ALC_CFG_RGN];
   wire [1:0] fast_recovery_speed = cfg_ff[`ALC_CFG_FST];

   // adc power wins over dac for the path choice
   wire nxt_recording = adc_left_power | adc_right_power;
   wire nxt_active = level_control_enable & (nxt_recording | dac_power);
   wire start = nxt_active & ~en_prev_ff;

   // sample magnitudes, 17 bits so that the most negative code does not overflow
   wire [16:0] mag_left = sample_left[15] ? (17'h00000 - {sample_left[15], sample_left})
                                          : {1'b0, sample_left};
   wire [16:0] mag_right = sample_right[15] ? (17'h00000 - {sample_right[15], sample_right})
                                            : {1'b0, sample_right};

   // detection level and the bottom of the reset band follow the threshold field
   reg [16:0] det_level;
   reg [16:0] rst_level;
   always @* begin
      case (limit_threshold_select)
         2'b00: begin
            det_level = `ALC_LVL_2P5;
            rst_level = `ALC_LVL_4P1;
         end
         2'b01: begin
            det_level = `ALC_LVL_4P1;
            rst_level = `ALC_LVL_6P0;
         end
         2'b10: begin
            det_level = `ALC_LVL_6P0;
            rst_level = `ALC_LVL_8P5;
         end
         default: begin
            det_level = `ALC_LVL_8P5;
            rst_level = `ALC_LVL_12P0;
         end
      endcase
   end

   // one detector per channel: limiter trigger, reset band and zero crossing
   wire over_left;
   wire over_right;
   wire band_left;
   wire band_right;
   wire zc_left;
   wire zc_right;
   alc_chan_det u_det_left (
      .mag(mag_left),
      .sample(sample_left),
      .sign_prev(sign_left_ff),
      .det_level(det_level),
      .rst_level(rst_level),
      .over(over_left),
      .above_rst(band_left),
      .zc(zc_left)
   );
   alc_chan_det u_det_right (
      .mag(mag_right),
      .sample(sample_right),
      .sign_prev(sign_right_ff),
      .det_level(det_level),
      .rst_level(rst_level),
      .over(over_right),
      .above_rst(band_right),
      .zc(zc_right)
   );

   // either channel over the detection level trips the limiter for both
   wire over = over_left | over_right;
   // over samples restart the wait on their own, so the band excludes them
   wire in_band = ~over & (band_left | band_right);

   // attenuation in gain steps; zero cross off forces a single step
   wire [7:0] att_steps = zero_cross_disable ? 8'h01 : (8'h01 << attenuation_step_select);
   wire [7:0] rec_steps = {6'h00, recovery_step_select} + 8'h01;

   // timeout and waiting lengths in sample periods
   wire [10:0] tmo_len = `ALC_ZTM_BASE << zero_cross_timeout_select;
   reg [3:0] fast_shift;
   always @* begin
      if (!impulse_ff) begin
         fast_shift = `ALC_FST_NONE;
      end else begin
         case (fast_recovery_speed)
            2'b00: fast_shift = `ALC_FST_X4;
            2'b01: fast_shift = `ALC_FST_X8;
            2'b10: fast_shift = `ALC_FST_X16;
            default: fast_shift = `ALC_FST_NONE; // invalid code runs at normal speed
         endcase
      end
   end
   wire [14:0] wait_len = (`ALC_WTM_BASE << recovery_wait_select) >> fast_shift;
   wire tmo_hit = (tmo_cnt_ff >= tmo_len - 11'h001);

   // common gain after one limiter or recovery step, clamped at both ends
   wire [7:0] gain_now = left_input_gain_code;
   wire [7:0] nxt_att = (gain_now > att_steps) ? (gain_now - att_steps) : `ALC_GAIN_MIN;
   wire [8:0] rec_sum = {1'b0, gain_now} + {1'b0, rec_steps};
   wire [7:0] ceil_eff = (recovery_ceiling_code_ff > `ALC_GAIN_MAX) ? `ALC_GAIN_MAX
                                                                    : recovery_ceiling_code_ff;
   wire [7:0] nxt_rec = (rec_sum > {1'b0, ceil_eff}) ? ceil_eff : rec_sum[7:0];
   wire pending = pend_left_ff | pend_right_ff;

   // apb decode; the answer is prepared in the setup cycle so pready comes from a flop
   wire setup = psel & ~penable & ~pready;
   wire wr_en = psel & penable & pready & pwrite & ~pslverr;
   reg [31:0] rd_val;
   reg rd_err;
   always @* begin
      rd_val = 32'h00000000;
      rd_err = 1'b0;
      case (paddr)
         `ALC_OFS_CTRL: rd_val = {27'h0000000, ctrl_ff};
         `ALC_OFS_CFG: rd_val = {19'h00000, cfg_ff};
         `ALC_OFS_CEIL: rd_val = {24'h000000, recovery_ceiling_code_ff};
         `ALC_OFS_LGAIN: rd_val = {24'h000000, man_left_ff};
         `ALC_OFS_RGAIN: rd_val = {24'h000000, man_right_ff};
         `ALC_OFS_STAT: begin
            rd_val[`ALC_ST_GL] = left_input_gain_code;
            rd_val[`ALC_ST_GR] = right_input_gain_code;
            rd_val[`ALC_ST_ACT] = level_control_active;
            rd_val[`ALC_ST_REC] = path_recording;
            rd_val[`ALC_ST_LIM] = limiting_ff;
            rd_val[`ALC_ST_IMP] = impulse_ff;
         end
         default: rd_err = 1'b1;
      endcase
   end

   // bus slave and register writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         ctrl_ff <= `ALC_RST_CTRL;
         cfg_ff <= `ALC_RST_CFG;
         recovery_ceiling_code_ff <= `ALC_RST_GAIN;
         man_left_ff <= `ALC_RST_GAIN;
         man_right_ff <= `ALC_RST_GAIN;
      end else if (ce) begin
         pready <= setup;
         if (setup) begin
            prdata <= pwrite ? 32'h00000000 : rd_val;
            pslverr <= rd_err | (pwrite & (paddr == `ALC_OFS_STAT));
         end else begin
            // the error flag stands only beside ready, never into the next transfer
            pslverr <= 1'b0;
         end
         if (wr_en) begin
            case (paddr)
               `ALC_OFS_CTRL: ctrl_ff <= pwdata[4:0];
               `ALC_OFS_CFG: cfg_ff <= pwdata[12:0];
               `ALC_OFS_CEIL: recovery_ceiling_code_ff <= pwdata[7:0];
               `ALC_OFS_LGAIN: begin
                  if (!level_control_active) begin
                     man_left_ff <= pwdata[7:0];
                  end
               end
               `ALC_OFS_RGAIN: begin
                  if (!level_control_active) begin
                     man_right_ff <= pwdata[7:0];
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // level control sequencer, one decision per sample period
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left_input_gain_code <= `ALC_RST_GAIN;
         right_input_gain_code <= `ALC_RST_GAIN;
         tgt_left_ff <= `ALC_RST_GAIN;
         tgt_right_ff <= `ALC_RST_GAIN;
         pend_left_ff <= 1'b0;
         pend_right_ff <= 1'b0;
         tmo_cnt_ff <= 11'h000;
         wait_cnt_ff <= 15'h0000;
         sign_left_ff <= 1'b0;
         sign_right_ff <= 1'b0;
         en_prev_ff <= 1'b0;
         limiting_ff <= 1'b0;
         over_prev_ff <= 1'b0;
         over_run_ff <= 1'b0;
         impulse_ff <= 1'b0;
         path_recording <= 1'b0;
         level_control_active <= 1'b0;
      end else if (ce) begin
         path_recording <= nxt_recording;
         level_control_active <= nxt_active;
         if (sample_valid) begin
            en_prev_ff <= nxt_active;
            sign_left_ff <= sample_left[15];
            sign_right_ff <= sample_right[15];
            over_prev_ff <= over;
            // pending changes land per channel at its own crossing or on timeout
            if (pending) begin
               tmo_cnt_ff <= tmo_cnt_ff + 11'h001;
            end
            if (pend_left_ff & (zc_left | tmo_hit)) begin
               left_input_gain_code <= tgt_left_ff;
               pend_left_ff <= 1'b0;
            end
            if (pend_right_ff & (zc_right | tmo_hit)) begin
               right_input_gain_code <= tgt_right_ff;
               pend_right_ff <= 1'b0;
            end
            if (start) begin
               // left gain becomes the common start value
               tgt_left_ff <= man_left_ff;
               tgt_right_ff <= man_left_ff;
               pend_left_ff <= 1'b1;
               pend_right_ff <= 1'b1;
               tmo_cnt_ff <= 11'h000;
               wait_cnt_ff <= 15'h0000;
               impulse_ff <= 1'b0;
               limiting_ff <= 1'b0;
            end else if (nxt_active) begin
               if (over) begin
                  wait_cnt_ff <= 15'h0000;
                  limiting_ff <= 1'b1;
                  impulse_ff <= 1'b0;
                  over_run_ff <= over_prev_ff;
                  if (zero_cross_disable) begin
                     // immediate one-step cut every sample, both channels equal
                     left_input_gain_code <= nxt_att;
                     right_input_gain_code <= nxt_att;
                     tgt_left_ff <= nxt_att;
                     tgt_right_ff <= nxt_att;
                     pend_left_ff <= 1'b0;
                     pend_right_ff <= 1'b0;
                  end else if (!pending) begin
                     // a new cut only after the previous one has landed on both sides
                     tgt_left_ff <= nxt_att;
                     tgt_right_ff <= nxt_att;
                     pend_left_ff <= 1'b1;
                     pend_right_ff <= 1'b1;
                     tmo_cnt_ff <= 11'h000;
                  end
               end else begin
                  limiting_ff <= 1'b0;
                  // a single-sample excursion counts as impulse noise
                  if (over_prev_ff & ~over_run_ff) begin
                     impulse_ff <= 1'b1;
                  end
                  if (gain_now >= ceil_eff) begin
                     impulse_ff <= 1'b0;
                  end
                  if (in_band) begin
                     wait_cnt_ff <= 15'h0000;
                  end else if (wait_cnt_ff >= wait_len - 15'h0001) begin
                     // a step still pending holds off the next one, so a long timeout paces it
                     if (!pending) begin
                        wait_cnt_ff <= 15'h0000;
                        if (gain_now < ceil_eff) begin
                           tgt_left_ff <= nxt_rec;
                           tgt_right_ff <= nxt_rec;
                           pend_left_ff <= 1'b1;
                           pend_right_ff <= 1'b1;
                           tmo_cnt_ff <= 11'h000;
                        end
                     end
                  end else begin
                     wait_cnt_ff <= wait_cnt_ff + 15'h0001;
                  end
               end
            end else begin
               // manual mode: follow the written codes at crossings or timeout
               limiting_ff <= 1'b0;
               impulse_ff <= 1'b0;
               wait_cnt_ff <= 15'h0000;
               if (tgt_left_ff != man_left_ff || tgt_right_ff != man_right_ff) begin
                  tgt_left_ff <= man_left_ff;
                  tgt_right_ff <= man_right_ff;
                  pend_left_ff <= 1'b1;
                  pend_right_ff <= 1'b1;
                  tmo_cnt_ff <= 11'h000;
               end
            end
         end
      end
   end

endmodule // alc_level_control

// per-channel level compare and zero-crossing detect, shared by both channels
module alc_chan_det (
   input wire [16:0] mag,
   input wire [15:0] sample,
   input wire sign_prev,
   input wire [16:0] det_level,
   input wire [16:0] rst_level,
   output wire over,
   output wire above_rst,
   output wire zc
);

   // compares are inclusive, so a sample exactly at a level counts as reaching it
   assign over = (mag >= det_level);
   assign above_rst = (mag >= rst_level);

   // a crossing is a sign flip against the previous sample, or an exact zero
   assign zc = (sample[15] != sign_prev) | (sample == 16'h0000);

endmodule // alc_chan_det

/* File: alc_lc_sva.sv */
// port-level assertion checker for the level control block
`timescale 1ns/1ps
module alc_lc_sva (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire pready,
   input wire pslverr,
   input wire sample_valid,
   input wire [7:0] left_input_gain_code,
   input wire [7:0] right_input_gain_code,
   input wire path_recording
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // apb phases seen from the slave side
   sequence s_setup;
      psel && !penable && !pready && ce;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   property p_answer; s_setup |=> s_access; endproperty
   property p_one_cycle; pready && ce |=> !pready; endproperty
   property p_err_ready; pslverr |-> pready; endproperty
   property p_ready_access; pready |-> psel && penable && $past(psel && !penable); endproperty
   // gains may only move on a sample strobe edge
   property p_left_strobe; !$past(sample_valid) |-> $stable(left_input_gain_code); endproperty
   property p_right_strobe; !$past(sample_valid) |-> $stable(right_input_gain_code); endproperty
   property p_clamp;
      left_input_gain_code <= 8'hF1 && right_input_gain_code <= 8'hF1;
   endproperty
   property p_reset_gain;
      $rose(presetn) |-> left_input_gain_code == 8'hE1 && right_input_gain_code == 8'hE1;
   endproperty
   // path select only follows a completed register write
   property p_path;
      $changed(path_recording) |-> $past(pwrite && pready) || $past(pwrite && pready, 2);
   endproperty
   a_answer: assert property (p_answer) else $error("no answer after setup");
   a_one_cycle: assert property (p_one_cycle) else $error("ready held too long");
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
   a_ready_access: assert property (p_ready_access) else $error("ready outside access");
   a_left_strobe: assert property (p_left_strobe) else $error("left gain moved off strobe");
   a_right_strobe: assert property (p_right_strobe) else $error("right gain moved off strobe");
   a_clamp: assert property (p_clamp) else $error("gain code above top");
   a_reset_gain: assert property (p_reset_gain) else $error("gain reset value");
   a_path: assert property (p_path) else $error("path moved without write");
endmodule // alc_lc_sva

bind alc_level_control alc_lc_sva u_sva (.pclk(pclk), .presetn(presetn), .ce(ce),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
   .sample_valid(sample_valid), .left_input_gain_code(left_input_gain_code),
   .right_input_gain_code(right_input_gain_code), .path_recording(path_recording));

/* File: alc_sample_src.sv */
// sample stream source standing for the converter path
`timescale 1ns/1ps
module alc_sample_src (
   input wire pclk,
   output logic sample_valid,
   output logic [15:0] sample_left,
   output logic [15:0] sample_right
);
   initial begin
      sample_valid = 1'b0;
      sample_left = 16'h0000;
      sample_right = 16'h0000;
   end
   // n strobes of value v four clocks apart; alt flips the sign each strobe
   task automatic play(input logic [15:0] v, input int n, input bit alt);
      logic [15:0] s;
      s = v;
      repeat (n) begin
         @(posedge pclk);
         sample_valid <= 1'b1;
         sample_left <= s;
         sample_right <= s;
         @(posedge pclk);
         sample_valid <= 1'b0;
         // data is meaningless between strobes, so scramble it
         sample_left <= ~s;
         sample_right <= ~s;
         repeat (2) @(posedge pclk);
         if (alt) s = -s;
      end
      repeat (2) @(posedge pclk);
   endtask
endmodule // alc_sample_src

/* File: testbench.sv */
// self-checking bench for the level control block
`timescale 1ns/1ps
`include "alc_regs.vh"
module testbench;
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
   logic sample_valid, path_recording, level_control_active;
   logic [7:0] paddr, gl, gr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] sample_left, sample_right;
   int n_errors = 0;
   int checks_done = 0;
   alc_level_control dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
      .sample_left(sample_left), .sample_right(sample_right), .left_input_gain_code(gl),
      .right_input_gain_code(gr), .path_recording(path_recording),
      .level_control_active(level_control_active));
   alc_sample_src src (.pclk(pclk), .sample_valid(sample_valid),
      .sample_left(sample_left), .sample_right(sample_right));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task summarize;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task gains(input logic [7:0] l, input logic [7:0] r);
      chk({24'h000000, gl}, {24'h000000, l});
      chk({24'h000000, gr}, {24'h000000, r});
   endtask
   // one apb transfer; the wait for ready is bounded
   task apb(input bit w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 16) begin
         n_errors++;
         summarize();
      end
   endtask
   task t_reset;
      apb(0, `ALC_OFS_CTRL, 0);
      chk(rd, 32'h00000000);
      apb(0, `ALC_OFS_STAT, 0);
      chk(rd, 32'h0000E1E1);
      apb(0, 8'h18, 0);
      chk({31'h00000000, er}, 32'h00000001);
      apb(1, `ALC_OFS_STAT, 32'h0000FFFF);
      chk({31'h00000000, er}, 32'h00000001);
   endtask
   // zero cross off: limiter, band reset, recovery, ceiling, impulse
   task t_zc_off;
      apb(1, `ALC_OFS_CEIL, 32'h000000E0);
      chk({31'h00000000, er}, 32'h00000000);
      // right manual gain differs, so the start value must come from the left one
      apb(1, `ALC_OFS_RGAIN, 32'h000000C6);
      apb(1, `ALC_OFS_CFG, 32'h0000020C);
      apb(1, `ALC_OFS_CTRL, 32'h00000007);
      // path and active flags follow the control register one cycle later
      repeat (2) @(posedge pclk);
      chk({31'h00000000, path_recording}, 32'h00000001);
      chk({31'h00000000, level_control_active}, 32'h00000001);
      src.play(16'h0100, 4, 1);
      gains(8'hE1, 8'hE1);
      src.play(16'h7000, 2, 0);
      gains(8'hDF, 8'hDF);
      src.play(16'h0100, 100, 1);
      src.play(16'h5000, 1, 0);
      src.play(16'h0100, 100, 1);
      gains(8'hDF, 8'hDF);
      src.play(16'h0100, 40, 1);
      gains(8'hE0, 8'hE0);
      src.play(16'h0100, 140, 1);
      gains(8'hE0, 8'hE0);
      src.play(16'h7000, 1, 0);
      gains(8'hDF, 8'hDF);
      src.play(16'h0100, 40, 1);
      gains(8'hE0, 8'hE0);
      apb(1, `ALC_OFS_CTRL, 32'h00000004);
      repeat (2) @(posedge pclk);
      chk({31'h00000000, level_control_active}, 32'h00000000);
   endtask
   // zero cross on: crossing-timed cut, manual gain lockout, timeout landing
   task t_zc_on;
      src.play(16'h0100, 4, 1);
      gains(8'hE1, 8'hC6);
      apb(1, `ALC_OFS_CFG, 32'h00000004);
      apb(1, `ALC_OFS_CTRL, 32'h00000005);
      apb(1, `ALC_OFS_LGAIN, 32'h00000050);
      apb(0, `ALC_OFS_LGAIN, 0);
      chk(rd, 32'h000000E1);
      src.play(16'h0100, 3, 1);
      src.play(16'h7000, 1, 0);
      gains(8'hE1, 8'hE1);
      src.play(16'hFF00, 1, 0);
      gains(8'hDF, 8'hDF);
      apb(1, `ALC_OFS_CTRL, 32'h00000004);
      apb(1, `ALC_OFS_LGAIN, 32'h00000050);
      src.play(16'h0100, 120, 0);
      gains(8'hDF, 8'hDF);
      src.play(16'h0100, 12, 0);
      gains(8'h50, 8'hC6);
   endtask
   // playback path only, lowest threshold and the largest limiter step
   task t_playback;
      apb(1, `ALC_OFS_CFG, 32'h0000000F);
      apb(1, `ALC_OFS_CTRL, 32'h00000011);
      repeat (2) @(posedge pclk);
      chk({31'h00000000, path_recording}, 32'h00000000);
      chk({31'h00000000, level_control_active}, 32'h00000001);
      src.play(16'h0100, 3, 1);
      gains(8'h50, 8'h50);
      src.play(16'h3100, 1, 0);
      gains(8'h50, 8'h50);
      src.play(16'hFF00, 1, 0);
      gains(8'h48, 8'h48);
   endtask
   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_zc_off();
      t_zc_on();
      t_playback();
      summarize();
   end
endmodule // testbench
